/* design/brake_seq_cfg.svh */
// Constants for the motor brake sequencer
`ifndef BRAKE_SEQ_CFG_SVH
`define BRAKE_SEQ_CFG_SVH
// Enable setting codes
`define BRAKE_EN_OFF 2'h0
`define BRAKE_EN_ON 2'h1
// Function assignment codes
`define FN_CONFIRM_IN 8'h2c
`define FN_RELEASE_OUT 8'h13
`define FN_ERROR_OUT 8'h14
// Error code reported on a brake trip
`define BRAKE_ERROR_CODE 8'h24
// Clock rate and wait tick (one wait unit is 10 ms at 100 MHz)
`define CLK_HZ 32'h05f5e100
`define WAIT_UNIT_MS 32'h0000000a
`define WAIT_UNIT_CYC ((`CLK_HZ / 32'h000003e8) * `WAIT_UNIT_MS)
// Longest wait setting, in 10 ms units (5.00 s)
`define WAIT_MAX 16'h01f4
// Frequency limit in 0.01 Hz units (400.00 Hz)
`define FREQ_MAX 16'h9c40
// Current threshold limits in percent of rated (2.00 and 1.80 times)
`define CURR_MAX_SMALL 16'h00c8
`define CURR_MAX_LARGE 16'h00b4
`endif

/* design/brake_seq_pkg.sv */
// Types for the motor brake sequencer
package brake_seq_pkg;
	// Sequence states
	typedef enum logic [3:0] {
		st_idle, st_ramp_release, st_establish, st_confirm_on, st_accel_wait,
		st_running, st_ramp_close, st_confirm_off, st_stop_wait, st_ramp_zero, st_trip
	} seq_state_type;
	// Settings from the drive parameter store
	typedef struct packed {
		logic [1:0] brake_ctrl_enable;
		logic [15:0] release_establish_wait;
		logic [15:0] accel_wait;
		logic [15:0] stop_wait;
		logic [15:0] confirm_timeout;
		logic [15:0] release_frequency;
		logic [15:0] release_current;
		logic [15:0] brake_close_frequency;
		logic large_rating;
	} brake_cfg_type;
	// Frequency command back to the ramp generator
	typedef struct packed {
		logic hold;
		logic [15:0] target;
	} freq_cmd_type;
endpackage

/* design/motor_brake_sequencer.sv */
// Brake open/close sequencer for the drive run and stop path
//
// Contract
// - Sequence runs only when enable code is 01
// - On run, ramp to release frequency, hold
// - At release frequency, wait, then assert release
// - Low current at wait end: trip, error
// - Confirm assigned: hold, timeout waiting confirm high
// - Confirm unassigned: skip timeout, proceed immediately
// - After confirm, accel wait, then resume ramp
// - Run removed: ramp to close frequency, release off
// - Confirm assigned: timeout waiting confirm low
// - After confirm low, stop wait, ramp to zero
// - Confirm drops while released: trip with error
// - Release and error offered as codes 19, 20
// - Frequencies accepted from 0 to 400 Hz
// - Release current limited to 2.00/1.80 rated
`include "brake_seq_cfg.svh"
module motor_brake_sequencer #(
	parameter int unsigned WAIT_UNIT_CYC = `WAIT_UNIT_CYC
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire brake_seq_pkg::brake_cfg_type cfg,
	input wire logic confirm_assigned,
	input wire logic run_cmd,
	input wire logic [15:0] set_frequency,
	input wire logic [15:0] output_frequency,
	input wire logic [15:0] output_current_pct,
	input wire logic brake_confirm_in,
	input wire logic trip_clear,
	output brake_seq_pkg::freq_cmd_type freq_cmd,
	output logic brake_release_out,
	output logic brake_error_out,
	output logic [7:0] error_code,
	output logic [7:0] release_fn_code,
	output logic [7:0] error_fn_code
);
	////////////////////////////////////////////////////////////////////////////////
	// Clamp a setting to its limit
	function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lim);
		clamp = (v > lim) ? lim : v;
	endfunction

	brake_seq_pkg::seq_state_type state; // Sequence state
	logic confirm_meta; // Synchroniser first stage
	logic confirm_sync; // Synchronised confirmation
	logic run_meta; // Run synchroniser first stage
	logic run_sync; // Synchronised run
	logic [31:0] tick_cnt; // Counts cycles of one wait unit
	logic [15:0] wait_cnt; // Elapsed wait units in the state
	logic tick; // One wait unit elapsed
	logic enabled; // Brake control selected
	logic [15:0] rel_f; // Clamped release frequency
	logic [15:0] close_f; // Clamped closing frequency
	logic [15:0] rel_i; // Clamped release current
	logic [15:0] est_w, acc_w, stp_w, cnf_w; // Clamped waits

	assign enabled = (cfg.brake_ctrl_enable == `BRAKE_EN_ON);
	assign rel_f = clamp(cfg.release_frequency, `FREQ_MAX);
	assign close_f = clamp(cfg.brake_close_frequency, `FREQ_MAX);
	assign rel_i = clamp(cfg.release_current,
		cfg.large_rating ? `CURR_MAX_LARGE : `CURR_MAX_SMALL);
	assign est_w = clamp(cfg.release_establish_wait, `WAIT_MAX);
	assign acc_w = clamp(cfg.accel_wait, `WAIT_MAX);
	assign stp_w = clamp(cfg.stop_wait, `WAIT_MAX);
	assign cnf_w = clamp(cfg.confirm_timeout, `WAIT_MAX);
	assign tick = (tick_cnt == WAIT_UNIT_CYC - 1);

	////////////////////////////////////////////////////////////////////////////////
	// Two-stage synchronisers for pin inputs
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			confirm_meta <= 1'b0;
			confirm_sync <= 1'b0;
			run_meta <= 1'b0;
			run_sync <= 1'b0;
		end else begin
			confirm_meta <= brake_confirm_in;
			confirm_sync <= confirm_meta;
			run_meta <= run_cmd;
			run_sync <= run_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Wait timer: restarts on every state change, cleared while disabled
	brake_seq_pkg::seq_state_type next_state;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			tick_cnt <= 32'h0;
			wait_cnt <= 16'h0;
		end else if (!enabled || next_state != state) begin
			tick_cnt <= 32'h0;
			wait_cnt <= 16'h0;
		end else if (tick) begin
			tick_cnt <= 32'h0;
			if (wait_cnt != 16'hffff) begin
				wait_cnt <= wait_cnt + 16'h1;
			end
		end else begin
			tick_cnt <= tick_cnt + 32'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		next_state = state;
		case (state)
			brake_seq_pkg::st_idle: begin
				if (run_sync) begin
					next_state = brake_seq_pkg::st_ramp_release;
				end
			end
			brake_seq_pkg::st_ramp_release: begin
				if (!run_sync) begin
					next_state = brake_seq_pkg::st_ramp_zero;
				end else if (output_frequency >= rel_f) begin
					next_state = brake_seq_pkg::st_establish;
				end
			end
			brake_seq_pkg::st_establish: begin
				if (wait_cnt >= est_w) begin
					if (output_current_pct < rel_i) begin
						next_state = brake_seq_pkg::st_trip;
					end else if (confirm_assigned) begin
						next_state = brake_seq_pkg::st_confirm_on;
					end else begin
						next_state = brake_seq_pkg::st_accel_wait;
					end
				end
			end
			brake_seq_pkg::st_confirm_on: begin
				if (confirm_sync) begin
					next_state = brake_seq_pkg::st_accel_wait;
				end else if (wait_cnt >= cnf_w) begin
					next_state = brake_seq_pkg::st_trip;
				end
			end
			brake_seq_pkg::st_accel_wait: begin
				if (confirm_assigned && !confirm_sync) begin
					next_state = brake_seq_pkg::st_trip;
				end else if (wait_cnt >= acc_w) begin
					next_state = brake_seq_pkg::st_running;
				end
			end
			brake_seq_pkg::st_running: begin
				if (confirm_assigned && !confirm_sync) begin
					next_state = brake_seq_pkg::st_trip;
				end else if (!run_sync) begin
					next_state = brake_seq_pkg::st_ramp_close;
				end
			end
			brake_seq_pkg::st_ramp_close: begin
				if (confirm_assigned && !confirm_sync) begin
					next_state = brake_seq_pkg::st_trip;
				end else if (output_frequency <= close_f) begin
					next_state = confirm_assigned ? brake_seq_pkg::st_confirm_off
						: brake_seq_pkg::st_stop_wait;
				end
			end
			brake_seq_pkg::st_confirm_off: begin
				if (!confirm_sync) begin
					next_state = brake_seq_pkg::st_stop_wait;
				end else if (wait_cnt >= cnf_w) begin
					next_state = brake_seq_pkg::st_trip;
				end
			end
			brake_seq_pkg::st_stop_wait: begin
				if (wait_cnt >= stp_w) begin
					next_state = brake_seq_pkg::st_ramp_zero;
				end
			end
			brake_seq_pkg::st_ramp_zero: begin
				if (output_frequency == 16'h0) begin
					next_state = brake_seq_pkg::st_idle;
				end
			end
			brake_seq_pkg::st_trip: begin
				if (trip_clear && !run_sync) begin
					next_state = brake_seq_pkg::st_idle;
				end
			end
			default: next_state = brake_seq_pkg::st_idle;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register; disable forces idle
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state <= brake_seq_pkg::st_idle;
		end else if (!enabled) begin
			state <= brake_seq_pkg::st_idle;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registered outputs
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			brake_release_out <= 1'b0;
			brake_error_out <= 1'b0;
			error_code <= 8'h0;
		end else if (!enabled) begin
			brake_release_out <= 1'b0;
			brake_error_out <= 1'b0;
			error_code <= 8'h0;
		end else begin
			// Release stands from establish end until close frequency reached
			brake_release_out <= (next_state == brake_seq_pkg::st_confirm_on)
				|| (next_state == brake_seq_pkg::st_accel_wait)
				|| (next_state == brake_seq_pkg::st_running)
				|| (next_state == brake_seq_pkg::st_ramp_close);
			brake_error_out <= (next_state == brake_seq_pkg::st_trip);
			if (next_state == brake_seq_pkg::st_trip) begin
				error_code <= `BRAKE_ERROR_CODE;
			end else if (next_state == brake_seq_pkg::st_idle) begin
				error_code <= 8'h0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Frequency command to the ramp generator
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			freq_cmd <= '0;
		end else if (!enabled) begin
			freq_cmd <= '{hold: 1'b0, target: run_sync ? set_frequency : 16'h0};
		end else begin
			case (next_state)
				brake_seq_pkg::st_ramp_release, brake_seq_pkg::st_establish,
				brake_seq_pkg::st_confirm_on, brake_seq_pkg::st_accel_wait:
					freq_cmd <= '{hold: 1'b1, target: rel_f};
				brake_seq_pkg::st_running:
					freq_cmd <= '{hold: 1'b0, target: set_frequency};
				brake_seq_pkg::st_ramp_close, brake_seq_pkg::st_confirm_off,
				brake_seq_pkg::st_stop_wait:
					freq_cmd <= '{hold: 1'b1, target: close_f};
				default:
					freq_cmd <= '{hold: 1'b0, target: 16'h0};
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Function codes offered for output assignment
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			release_fn_code <= 8'h0;
			error_fn_code <= 8'h0;
		end else begin
			release_fn_code <= `FN_RELEASE_OUT;
			error_fn_code <= `FN_ERROR_OUT;
		end
	end
endmodule // motor_brake_sequencer

/* dv/brake_model.sv */
// Behavioural brake with a release confirmation contact
module brake_model (
	input wire logic mclk,
	input wire logic release_cmd,
	input wire logic [7:0] delay_cyc,
	input wire logic fault_drop,
	output logic confirm
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt = 8'h00; // Cycles since the command last changed
	logic last = 1'b0; // Command seen on the previous edge
	initial confirm = 1'b0;
	// Contact follows the command after delay_cyc; 8'hff never follows (stuck)
	always @(posedge mclk) begin
		cnt <= (release_cmd != last) ? 8'h00 : ((cnt == 8'hfe) ? cnt : cnt + 8'h01);
		last <= release_cmd;
		if (fault_drop) begin
			confirm <= 1'b0;
		end else if (cnt == delay_cyc) begin
			confirm <= release_cmd;
		end
	end
endmodule // brake_model

/* dv/motor_brake_sequencer_sva.sv */
// Port-level checks of the brake sequencer
module motor_brake_sequencer_sva #(
	parameter int unsigned WAIT_UNIT_CYC = 10
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire brake_seq_pkg::brake_cfg_type cfg,
	input wire logic run_cmd,
	input wire logic trip_clear,
	input wire logic [15:0] output_frequency,
	input wire logic [15:0] output_current_pct,
	input wire brake_seq_pkg::freq_cmd_type freq_cmd,
	input wire logic brake_release_out,
	input wire logic brake_error_out,
	input wire logic [7:0] error_code,
	input wire logic [7:0] release_fn_code,
	input wire logic [7:0] error_fn_code
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	// Settings after their limits, as the sequencer must apply them
	logic [15:0] rel_f_lim; // Release frequency capped at 400.00 Hz
	logic [15:0] cur_lim; // Release current capped by the rating
	assign rel_f_lim = (cfg.release_frequency > 16'h9c40) ? 16'h9c40 : cfg.release_frequency;
	assign cur_lim = (cfg.release_current > (cfg.large_rating ? 16'h00b4 : 16'h00c8))
		? (cfg.large_rating ? 16'h00b4 : 16'h00c8) : cfg.release_current;
	// Brake opening and normal closing events
	sequence release_opens; $rose(brake_release_out); endsequence
	sequence release_shuts; $fell(brake_release_out) && !brake_error_out; endsequence
	chk_idle_quiet:
	assert property ((cfg.brake_ctrl_enable != 2'h1) [*2] |-> !brake_release_out && !brake_error_out)
		else $error("brake outputs active while disabled");
	chk_fn_codes:
	assert property ($past(rstn) |-> release_fn_code == 8'h13 && error_fn_code == 8'h14)
		else $error("function codes wrong");
	chk_error_code:
	assert property (brake_error_out |-> error_code == 8'h24) else $error("error code wrong");
	chk_open_held:
	assert property (release_opens |-> freq_cmd.hold) else $error("no hold after release");
	chk_open_current:
	assert property (release_opens |-> $past(output_current_pct) >= $past(cur_lim))
		else $error("release with low current");
	chk_ramp_target:
	assert property ($rose(freq_cmd.hold) && !brake_release_out && !brake_error_out
		|-> freq_cmd.target == rel_f_lim) else $error("start ramp target wrong");
	chk_close_freq:
	assert property (release_shuts |-> $past(output_frequency) <= $past(cfg.brake_close_frequency))
		else $error("brake closed above close frequency");
	chk_error_holds:
	assert property (brake_error_out && cfg.brake_ctrl_enable == 2'h1 && (run_cmd || !trip_clear)
		|=> brake_error_out) else $error("error dropped early");
endmodule // motor_brake_sequencer_sva
bind motor_brake_sequencer motor_brake_sequencer_sva #(.WAIT_UNIT_CYC(WAIT_UNIT_CYC)) chk_u (
	.mclk, .rstn, .cfg, .run_cmd, .trip_clear, .output_frequency, .output_current_pct, .freq_cmd,
	.brake_release_out, .brake_error_out, .error_code, .release_fn_code, .error_fn_code);

/* dv/testbench.sv */
// Self-checking bench for the brake sequencer
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0, rstn = 1'b0, confirm_assigned = 1'b0, run_cmd = 1'b0, trip_clear = 1'b0;
	logic brake_confirm_in, brake_release_out, brake_error_out, confirm_drop = 1'b0;
	logic [15:0] set_frequency = 16'h1388, output_frequency = 16'h0000, output_current_pct = 16'h0064;
	logic [7:0] error_code, release_fn_code, error_fn_code, confirm_delay = 8'h03;
	brake_seq_pkg::brake_cfg_type cfg;
	brake_seq_pkg::freq_cmd_type freq_cmd;
	int failures = 0, samples_checked = 0, cycles = 0, n;
	motor_brake_sequencer #(.WAIT_UNIT_CYC(10)) dut_u (.mclk, .rstn, .cfg, .confirm_assigned,
		.run_cmd, .set_frequency, .output_frequency, .output_current_pct, .brake_confirm_in,
		.trip_clear, .freq_cmd, .brake_release_out, .brake_error_out, .error_code,
		.release_fn_code, .error_fn_code);
	brake_model brake_u (.mclk, .release_cmd(brake_release_out), .delay_cyc(confirm_delay),
		.fault_drop(confirm_drop), .confirm(brake_confirm_in));
	initial forever #5 mclk = ~mclk;
	// Ideal ramp generator: output frequency follows the command next cycle
	always @(posedge mclk) output_frequency <= freq_cmd.target;
	// Hang guard
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			report_and_stop();
		end
	end
	task check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Out-of-range release frequency and current settle at their limits
	task t_clamps;
		@(posedge mclk);
		cfg.release_frequency <= 16'hffff;
		cfg.release_current <= 16'h00ff;
		cfg.large_rating <= 1'b1;
		output_current_pct <= 16'h00b4;
		confirm_assigned <= 1'b0;
		confirm_delay <= 8'hff;
		run_cmd <= 1'b1;
		for (n = 0; n < 300 && !freq_cmd.hold; n++) @(negedge mclk);
		check(freq_cmd.target, 16'h9c40);
		for (n = 0; n < 300 && !brake_release_out && !brake_error_out; n++) @(negedge mclk);
		check(brake_release_out, 1'b1);
		check(brake_error_out, 1'b0);
		@(posedge mclk);
		run_cmd <= 1'b0;
		for (n = 0; n < 300 && (brake_release_out || freq_cmd.target != 16'h0000); n++)
			@(negedge mclk);
		@(posedge mclk);
		cfg.release_frequency <= 16'h01f4;
		cfg.release_current <= 16'h0032;
		cfg.large_rating <= 1'b0;
		output_current_pct <= 16'h0064;
		repeat (10) @(posedge mclk);
	endtask
	// Run with the sequence switched off
	task t_disabled;
		@(posedge mclk);
		cfg.brake_ctrl_enable <= 2'h0;
		run_cmd <= 1'b1;
		repeat (40) @(negedge mclk);
		check(brake_release_out, 1'b0);
		check(brake_error_out, 1'b0);
		@(posedge mclk);
		run_cmd <= 1'b0;
		cfg.brake_ctrl_enable <= 2'h1;
		repeat (10) @(posedge mclk);
	endtask
	// Start/stop cycle; fault 1 low current, 2 no confirm, 3 confirm drop, 4 stuck at stop
	task run_seq(input logic assigned, input logic [2:0] fault);
		@(posedge mclk);
		confirm_assigned <= assigned;
		output_current_pct <= (fault == 3'h1) ? 16'h0010 : 16'h0064;
		confirm_delay <= (fault == 3'h2 || !assigned) ? 8'hff : 8'h03;
		run_cmd <= 1'b1;
		for (n = 0; n < 300 && !brake_release_out && !brake_error_out; n++) @(negedge mclk);
		if (fault == 3'h1) check(brake_release_out, 1'b0);
		for (n = 0; n < 300 && freq_cmd.hold && !brake_error_out; n++) @(negedge mclk);
		if (fault == 3'h0) check(freq_cmd.target, set_frequency);
		@(posedge mclk);
		confirm_drop <= (fault == 3'h3);
		if (fault == 3'h4) confirm_delay <= 8'hff;
		run_cmd <= (fault == 3'h3);
		for (n = 0; n < 300 && brake_release_out && !brake_error_out; n++) @(negedge mclk);
		if (fault == 3'h0) check(output_frequency <= cfg.brake_close_frequency, 1'b1);
		for (n = 0; n < 300 && freq_cmd.target != 16'h0000 && !brake_error_out; n++) @(negedge mclk);
		if (fault == 3'h0) check(n >= 9, 1'b1);
		// Look at settled outputs, away from the edge that updates them
		@(negedge mclk);
		check(brake_error_out, fault != 3'h0);
		check(error_code, (fault != 3'h0) ? 8'h24 : 8'h00);
		@(posedge mclk);
		run_cmd <= 1'b0;
		trip_clear <= 1'b1;
		confirm_drop <= 1'b0;
		confirm_delay <= 8'h03;
		repeat (8) @(posedge mclk);
		trip_clear <= 1'b0;
		repeat (4) @(negedge mclk);
		check(brake_error_out, 1'b0);
	endtask
	initial begin
		cfg = '{2'h1, 16'h0002, 16'h0001, 16'h0001, 16'h0005,
			16'h01f4, // Release at 5.00 Hz, kept above the starting frequency
			16'h0032, 16'h012c, 1'b0};
		repeat (20) @(posedge mclk);
		rstn <= 1'b1;
		repeat (2) @(negedge mclk);
		check(release_fn_code, 8'h13);
		check(error_fn_code, 8'h14);
		t_disabled;
		run_seq(1'b0, 3'h0);
		t_clamps;
		for (int f = 0; f < 5; f++) run_seq(1'b1, f[2:0]);
		report_and_stop;
	end
endmodule // testbench
